/* design/eer_pkg.sv */
// Constants and types shared by the error exit response logic.
package eer_pkg;

    // Width of one central memory word.
    localparam int WORD_W = 60;
    // Width of a program address.
    localparam int ADDR_W = 18;
    // Width of the exit condition code field.
    localparam int CODE_W = 6;
    // Lowest bit of the exit condition code inside the exit word.
    localparam int CODE_LSB = 48;
    // Lowest bit of the program address inside the exit word.
    localparam int PADDR_LSB = 30;

    // Exit condition codes: address fault, infinite, indefinite, hardware error.
    localparam logic [CODE_W-1:0] CODE_ADDR = 6'h01;
    localparam logic [CODE_W-1:0] CODE_INF = 6'h02;
    localparam logic [CODE_W-1:0] CODE_INDEF = 6'h04;
    localparam logic [CODE_W-1:0] CODE_HW = 6'h10;
    localparam logic [CODE_W-1:0] CODE_NONE = 6'h00;

    // Condition flag bits 48, 49 and 50 as seen by software.
    localparam int FLAG_W = 3;
    localparam logic [FLAG_W-1:0] FLAG_ADDR = 3'h1;
    localparam logic [FLAG_W-1:0] FLAG_INF = 3'h2;
    localparam logic [FLAG_W-1:0] FLAG_INDEF = 3'h4;
    localparam logic [FLAG_W-1:0] FLAG_NONE = 3'h0;

    // Sequencer states.
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_STORE,
        ST_INTR,
        ST_STORE_LATE,
        ST_HALTED
    } eer_state_type;

endpackage

/* design/eer_error_exit.sv */
// Error exit response sequencer for the older-architecture monitor mode.
`timescale 1ns/1ps

// Functional notes
// - Move address fault suppresses all memory access.
// - Move fault, exit mode: store, interrupt, halt.
// - Move fault, no exit mode: resume next.
// - 011/012 fault executes as a pass.
// - 011/012 exit mode: store code, interrupt, halt.
// - 011/012 no exit: interrupt, next word.
// - 014/015 exit: pass, store following address, halt.
// - 014/015 no exit: pass, next parcel.
// - Infinite sets 49, indefinite 50; else continue.
// - Arithmetic exit mode: store 02/04, halt.
// - Hardware error: interrupt, then store 20, halt.
// - Active only while monitor flag is one.
module eer_error_exit #(
    parameter int ADDR_W = eer_pkg::ADDR_W
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Mode controls.
    input wire logic monitorFlag,
    input wire logic exitModeSel,
    // Fault events from the execution pipeline, one-cycle pulses.
    input wire logic moveAddrFault,
    input wire logic passFaultWord,
    input wire logic passFaultParcel,
    input wire logic infiniteResult,
    input wire logic indefiniteResult,
    input wire logic hwParityError,
    input wire logic hwDoubleBitError,
    // Addresses supplied with the event.
    input wire logic [ADDR_W-1:0] progAddr,
    input wire logic [ADDR_W-1:0] followAddr,
    input wire logic [ADDR_W-1:0] centralReferenceBase,
    // Restart from the halted state.
    input wire logic haltRelease,
    // Actions towards the pipeline.
    output logic suppressMemAccess,
    output logic passInstr,
    output logic resumeNext,
    output logic advanceWord,
    output logic advanceParcel,
    output logic interruptNative,
    output logic cpuHalted,
    // Exit word write towards central memory.
    output logic exitWordWrite,
    output logic [ADDR_W-1:0] exitWordAddr,
    output logic [eer_pkg::WORD_W-1:0] exitWordData,
    // Condition flags 48, 49, 50.
    output logic [eer_pkg::FLAG_W-1:0] exitCondFlags
);

    // Whole module state in one record.
    typedef struct packed {
        eer_pkg::eer_state_type state;
        logic suppress;
        logic pass;
        logic resume;
        logic advWord;
        logic advParcel;
        logic intr;
        logic halted;
        logic wr;
        logic [ADDR_W-1:0] wrAddr;
        logic [eer_pkg::WORD_W-1:0] wrData;
        logic [eer_pkg::FLAG_W-1:0] flags;
        logic [ADDR_W-1:0] pLatch;
        logic [eer_pkg::CODE_W-1:0] codeLatch;
    } eer_regs_type;

    // Registered state and its next value.
    eer_regs_type regs_ff;
    eer_regs_type nxt_regs;

    // Packs the program address and exit code into one memory word.
    function automatic logic [eer_pkg::WORD_W-1:0] packExit(
        input logic [ADDR_W-1:0] pAddr,
        input logic [eer_pkg::CODE_W-1:0] code
    );
        logic [eer_pkg::WORD_W-1:0] w;
        w = '0;
        w[eer_pkg::CODE_LSB +: eer_pkg::CODE_W] = code;
        w[eer_pkg::PADDR_LSB +: ADDR_W] = pAddr;
        return w;
    endfunction

    // Either hardware error; it outranks every other event in the idle state.
    logic hwError;
    assign hwError = hwParityError | hwDoubleBitError;

    // Next-state logic. Events are only accepted when idle, so a second
    // fault during an exit sequence is dropped; the pipeline is expected
    // to be stalled by then anyway. Hardware errors take priority because
    // a corrupted word makes every other report untrustworthy.
    always_comb
    begin
        nxt_regs = regs_ff;
        // Action strobes last a single cycle.
        nxt_regs.suppress = 1'b0;
        nxt_regs.pass = 1'b0;
        nxt_regs.resume = 1'b0;
        nxt_regs.advWord = 1'b0;
        nxt_regs.advParcel = 1'b0;
        nxt_regs.intr = 1'b0;
        nxt_regs.wr = 1'b0;
        unique case (regs_ff.state)
            eer_pkg::ST_IDLE:
            begin
                // Outside monitor mode this logic stays silent.
                if (monitorFlag)
                begin
                    if (hwError)
                    begin
                        // Interrupt first, the store follows from native state.
                        nxt_regs.intr = 1'b1;
                        nxt_regs.pLatch = progAddr;
                        nxt_regs.codeLatch = eer_pkg::CODE_HW;
                        nxt_regs.state = eer_pkg::ST_STORE_LATE;
                    end
                    else if (moveAddrFault)
                    begin
                        nxt_regs.suppress = 1'b1;
                        nxt_regs.flags = eer_pkg::FLAG_ADDR;
                        if (exitModeSel)
                        begin
                            nxt_regs.pLatch = progAddr;
                            nxt_regs.codeLatch = eer_pkg::CODE_ADDR;
                            nxt_regs.state = eer_pkg::ST_STORE;
                        end
                        else
                        begin
                            nxt_regs.resume = 1'b1;
                        end
                    end
                    else if (passFaultWord)
                    begin
                        nxt_regs.pass = 1'b1;
                        nxt_regs.flags = eer_pkg::FLAG_ADDR;
                        if (exitModeSel)
                        begin
                            nxt_regs.pLatch = progAddr;
                            nxt_regs.codeLatch = eer_pkg::CODE_ADDR;
                            nxt_regs.state = eer_pkg::ST_STORE;
                        end
                        else
                        begin
                            // Interrupt, then go on with the next whole word.
                            nxt_regs.intr = 1'b1;
                            nxt_regs.advWord = 1'b1;
                        end
                    end
                    else if (passFaultParcel)
                    begin
                        nxt_regs.pass = 1'b1;
                        nxt_regs.flags = eer_pkg::FLAG_ADDR;
                        if (exitModeSel)
                        begin
                            // The stored address points past the passed instruction.
                            nxt_regs.pLatch = followAddr;
                            nxt_regs.codeLatch = eer_pkg::CODE_ADDR;
                            nxt_regs.state = eer_pkg::ST_STORE;
                        end
                        else
                        begin
                            nxt_regs.advParcel = 1'b1;
                        end
                    end
                    else if (indefiniteResult | infiniteResult)
                    begin
                        // Indefinite wins when both appear; it is the stronger result.
                        nxt_regs.flags = indefiniteResult ? eer_pkg::FLAG_INDEF
                                                          : eer_pkg::FLAG_INF;
                        if (exitModeSel)
                        begin
                            nxt_regs.pLatch = progAddr;
                            nxt_regs.codeLatch = indefiniteResult ? eer_pkg::CODE_INDEF
                                                                  : eer_pkg::CODE_INF;
                            nxt_regs.state = eer_pkg::ST_STORE;
                        end
                        else
                        begin
                            nxt_regs.resume = 1'b1;
                        end
                    end
                end
            end
            eer_pkg::ST_STORE:
            begin
                // Exit word goes out before the interrupt.
                nxt_regs.wr = 1'b1;
                nxt_regs.wrAddr = centralReferenceBase;
                nxt_regs.wrData = packExit(regs_ff.pLatch, regs_ff.codeLatch);
                nxt_regs.state = eer_pkg::ST_INTR;
            end
            eer_pkg::ST_INTR:
            begin
                nxt_regs.intr = 1'b1;
                nxt_regs.halted = 1'b1;
                nxt_regs.state = eer_pkg::ST_HALTED;
            end
            eer_pkg::ST_STORE_LATE:
            begin
                // Native state records the hardware error and stops.
                nxt_regs.wr = 1'b1;
                nxt_regs.wrAddr = centralReferenceBase;
                nxt_regs.wrData = packExit(regs_ff.pLatch, regs_ff.codeLatch);
                nxt_regs.halted = 1'b1;
                nxt_regs.state = eer_pkg::ST_HALTED;
            end
            eer_pkg::ST_HALTED:
            begin
                // Only an explicit release leaves the stop.
                if (haltRelease)
                begin
                    nxt_regs.halted = 1'b0;
                    nxt_regs.flags = eer_pkg::FLAG_NONE;
                    nxt_regs.state = eer_pkg::ST_IDLE;
                end
            end
            default:
            begin
                nxt_regs.state = eer_pkg::ST_IDLE;
            end
        endcase
    end

    // State register.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            regs_ff <= '{state: eer_pkg::ST_IDLE, codeLatch: eer_pkg::CODE_NONE, default: '0};
        end
        else
        begin
            regs_ff <= nxt_regs;
        end
    end

    // Outputs straight from the state register.
    assign suppressMemAccess = regs_ff.suppress;
    assign passInstr = regs_ff.pass;
    assign resumeNext = regs_ff.resume;
    assign advanceWord = regs_ff.advWord;
    assign advanceParcel = regs_ff.advParcel;
    assign interruptNative = regs_ff.intr;
    assign cpuHalted = regs_ff.halted;
    assign exitWordWrite = regs_ff.wr;
    assign exitWordAddr = regs_ff.wrAddr;
    assign exitWordData = regs_ff.wrData;
    assign exitCondFlags = regs_ff.flags;

    // Checks on the sequencer.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // The sequencer can take an event only when idle and in monitor mode.
    logic idleHit;
    assign idleHit = regs_ff.state == eer_pkg::ST_IDLE && monitorFlag;

    a_move_suppress: assert property (
        idleHit && !hwError && moveAddrFault |=> suppressMemAccess && !exitWordWrite)
        else $error("move fault did not suppress memory access");
    a_move_exit_seq: assert property (
        idleHit && !hwError && moveAddrFault && exitModeSel
        |=> ##1 exitWordWrite
        && exitWordData[eer_pkg::CODE_LSB +: eer_pkg::CODE_W] == eer_pkg::CODE_ADDR
        ##1 interruptNative && cpuHalted)
        else $error("move fault exit sequence wrong");
    a_move_resume: assert property (
        idleHit && !hwError && moveAddrFault && !exitModeSel
        |=> resumeNext ##1 !exitWordWrite)
        else $error("move fault without exit did not resume");
    a_word_pass: assert property (
        idleHit && !hwError && !moveAddrFault && passFaultWord && !exitModeSel
        |=> passInstr && interruptNative && advanceWord && !cpuHalted)
        else $error("pass fault word sequence wrong");
    a_word_exit: assert property (
        idleHit && !hwError && !moveAddrFault && passFaultWord && exitModeSel
        |=> passInstr ##1 exitWordWrite
        && exitWordData[eer_pkg::PADDR_LSB +: ADDR_W] == $past(progAddr, 2)
        ##1 interruptNative && cpuHalted)
        else $error("pass fault word exit sequence wrong");
    a_parcel_follow: assert property (
        idleHit && !hwError && !moveAddrFault && !passFaultWord && passFaultParcel
        && exitModeSel |=> passInstr ##1 exitWordWrite
        && exitWordData[eer_pkg::PADDR_LSB +: ADDR_W] == $past(followAddr, 2))
        else $error("parcel fault stored wrong address");
    a_parcel_nexit: assert property (
        idleHit && !hwError && !moveAddrFault && !passFaultWord && passFaultParcel
        && !exitModeSel |=> advanceParcel && !interruptNative)
        else $error("parcel fault without exit wrong");
    a_hw_order: assert property (
        idleHit && hwError |=> interruptNative && !exitWordWrite ##1 exitWordWrite
        && exitWordData[eer_pkg::CODE_LSB +: eer_pkg::CODE_W] == eer_pkg::CODE_HW ##1 cpuHalted)
        else $error("hardware error sequence wrong");
    a_job_silent: assert property (
        regs_ff.state == eer_pkg::ST_IDLE && !monitorFlag |=> regs_ff.state == eer_pkg::ST_IDLE
        && !suppressMemAccess && !passInstr && !interruptNative)
        else $error("acted outside monitor mode");
    a_arith_code: assert property (
        idleHit && !hwError && !moveAddrFault && !passFaultWord && !passFaultParcel
        && indefiniteResult && exitModeSel
        |=> exitCondFlags == eer_pkg::FLAG_INDEF
        ##1 exitWordData[eer_pkg::CODE_LSB +: eer_pkg::CODE_W] == eer_pkg::CODE_INDEF)
        else $error("indefinite exit code wrong");
    a_inf_resume: assert property (
        idleHit && !hwError && !moveAddrFault && !passFaultWord && !passFaultParcel
        && infiniteResult && !indefiniteResult && !exitModeSel
        |=> exitCondFlags == eer_pkg::FLAG_INF && resumeNext && !cpuHalted)
        else $error("infinite result without exit did not continue");

endmodule

/* verif/eer_mem_model.sv */
// Central memory model that receives the exit words stored by the sequencer.
`timescale 1ns/1ps

module eer_mem_model (
    // Clock and reset.
    input wire logic clk,
    input wire logic resetn,
    // Exit word write from the sequencer.
    input wire logic exitWordWrite,
    input wire logic [eer_pkg::ADDR_W-1:0] exitWordAddr,
    input wire logic [eer_pkg::WORD_W-1:0] exitWordData,
    // Read-back port for the bench.
    input wire logic [3:0] rdAddr,
    output logic [eer_pkg::WORD_W-1:0] rdData,
    output logic [7:0] writeCount
);
    // Sixteen words cover every reference location that the bench uses.
    logic [eer_pkg::WORD_W-1:0] memWords [16];

    // Untouched words hold all ones, which no exit word can carry, so a lost store shows.
    initial
    begin
        for (int i = 0; i < 16; i++)
            memWords[i] = {eer_pkg::WORD_W{1'b1}};
    end

    // Store each strobed word and count the stores; memory contents survive reset.
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            writeCount <= 8'h00;
        else if (exitWordWrite)
        begin
            memWords[exitWordAddr[3:0]] <= exitWordData;
            writeCount <= writeCount + 8'h01;
        end
    end

    // Reads are combinational so the bench sees a store one cycle after its strobe.
    assign rdData = memWords[rdAddr];
endmodule

/* verif/error_exit_response_logic_test.sv */
// Self-checking bench for the error exit response sequencer.
`timescale 1ns/1ps

module error_exit_response_logic_test;
    // Clock, reset and mode controls.
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic monitorFlag = 1'b0;
    logic exitModeSel = 1'b0;
    logic haltRelease = 1'b0;
    // One bit per fault event: move, word pass, parcel pass, infinite, indefinite, parity, double.
    logic [6:0] ev = 7'h00;
    // Addresses handed over with each event.
    logic [eer_pkg::ADDR_W-1:0] progAddr = 18'h00000;
    logic [eer_pkg::ADDR_W-1:0] followAddr = 18'h00000;
    logic [eer_pkg::ADDR_W-1:0] centralReferenceBase = 18'h00000;
    // Design outputs.
    logic supp, pass, resume, advW, advP, intr, halted, wr;
    logic [eer_pkg::ADDR_W-1:0] exitWordAddr;
    logic [eer_pkg::WORD_W-1:0] exitWordData;
    logic [eer_pkg::FLAG_W-1:0] exitCondFlags;
    // Memory model read-back.
    logic [eer_pkg::WORD_W-1:0] rdData;
    logic [7:0] writeCount;
    // All action strobes in one vector, the store strobe in bit 0.
    logic [7:0] outs;
    int n_mismatch = 0;
    int compares = 0;

    assign outs = {supp, pass, resume, advW, advP, intr, halted, wr};

    eer_error_exit u_eer_error_exit (
        .clk(clk), .resetn(resetn), .monitorFlag(monitorFlag), .exitModeSel(exitModeSel),
        .moveAddrFault(ev[0]), .passFaultWord(ev[1]), .passFaultParcel(ev[2]),
        .infiniteResult(ev[3]), .indefiniteResult(ev[4]), .hwParityError(ev[5]),
        .hwDoubleBitError(ev[6]), .progAddr(progAddr), .followAddr(followAddr),
        .centralReferenceBase(centralReferenceBase), .haltRelease(haltRelease),
        .suppressMemAccess(supp), .passInstr(pass), .resumeNext(resume), .advanceWord(advW),
        .advanceParcel(advP), .interruptNative(intr), .cpuHalted(halted), .exitWordWrite(wr),
        .exitWordAddr(exitWordAddr), .exitWordData(exitWordData), .exitCondFlags(exitCondFlags)
    );

    eer_mem_model u_eer_mem_model (
        .clk(clk), .resetn(resetn), .exitWordWrite(wr), .exitWordAddr(exitWordAddr),
        .exitWordData(exitWordData), .rdAddr(centralReferenceBase[3:0]), .rdData(rdData),
        .writeCount(writeCount)
    );

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // Prints the verdict and ends the run.
    task automatic results();
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Compares the action strobe vector.
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t actions %h expected %h", $time, got, exp);
        end
    endtask

    // Compares a word, address, flag or count value.
    task automatic chkw(input logic [59:0] got, input logic [59:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t value %h expected %h", $time, got, exp);
        end
    endtask

    // Pulses one event and checks the three following cycles; a halted end is released.
    task automatic seq(input int idx, input logic em, input logic [7:0] o1, input logic [7:0] o2,
                       input logic [7:0] o3, input logic [2:0] fl, input logic [5:0] code,
                       input logic pf);
        logic [17:0] p;
        logic [17:0] b;
        logic [59:0] word;
        logic [7:0] n0;
        p = 18'h2a000 + 18'(idx);
        b = 18'h00002 + 18'(idx);
        // The word packs the code above the address with every other bit clear.
        word = {6'h00, code, (pf ? p + 18'h00001 : p), 30'h00000000};
        n0 = writeCount;
        @(posedge clk);
        ev <= 7'(7'h01 << idx);
        exitModeSel <= em;
        progAddr <= p;
        followAddr <= p + 18'h00001;
        centralReferenceBase <= b;
        @(posedge clk);
        ev <= 7'h00;
        #1;
        chk8(outs, o1);
        if (code != eer_pkg::CODE_HW)
            chkw(60'(exitCondFlags), 60'(fl));
        @(posedge clk);
        #1;
        chk8(outs, o2);
        if (o2[0])
        begin
            chkw(60'(exitWordAddr), 60'(b));
            chkw(exitWordData, word);
        end
        @(posedge clk);
        #1;
        chk8(outs, o3);
        // Exactly one store per exit and none on a plain continue.
        chkw(60'(writeCount - n0), 60'(o2[0]));
        if (o2[0])
            chkw(rdData, word);
        if (o3[1])
        begin
            // A new event while halted must leave the stopped state untouched.
            @(posedge clk);
            ev <= 7'h01;
            @(posedge clk);
            ev <= 7'h00;
            haltRelease <= 1'b1;
            #1;
            chk8(outs, 8'h02);
            @(posedge clk);
            haltRelease <= 1'b0;
            #1;
            chk8(outs, 8'h00);
            chkw(60'(exitCondFlags), 60'h0);
        end
    endtask

    // Watchdog sized far beyond the roughly 130 cycles the tests need.
    initial
    begin
        #20000;
        n_mismatch++;
        results();
    end

    // Main sequence: monitor flag off first, then every event in both exit modes.
    initial
    begin
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 7; i++)
            seq(i, 1'b1, 8'h00, 8'h00, 8'h00, eer_pkg::FLAG_NONE, eer_pkg::CODE_NONE, 1'b0);
        @(posedge clk);
        monitorFlag <= 1'b1;
        seq(0, 1'b0, 8'ha0, 8'h00, 8'h00, eer_pkg::FLAG_ADDR, eer_pkg::CODE_ADDR, 1'b0);
        seq(0, 1'b1, 8'h80, 8'h01, 8'h06, eer_pkg::FLAG_ADDR, eer_pkg::CODE_ADDR, 1'b0);
        seq(1, 1'b1, 8'h40, 8'h01, 8'h06, eer_pkg::FLAG_ADDR, eer_pkg::CODE_ADDR, 1'b0);
        seq(1, 1'b0, 8'h54, 8'h00, 8'h00, eer_pkg::FLAG_ADDR, eer_pkg::CODE_ADDR, 1'b0);
        seq(2, 1'b1, 8'h40, 8'h01, 8'h06, eer_pkg::FLAG_ADDR, eer_pkg::CODE_ADDR, 1'b1);
        seq(2, 1'b0, 8'h48, 8'h00, 8'h00, eer_pkg::FLAG_ADDR, eer_pkg::CODE_ADDR, 1'b1);
        seq(3, 1'b0, 8'h20, 8'h00, 8'h00, eer_pkg::FLAG_INF, eer_pkg::CODE_INF, 1'b0);
        seq(3, 1'b1, 8'h00, 8'h01, 8'h06, eer_pkg::FLAG_INF, eer_pkg::CODE_INF, 1'b0);
        seq(4, 1'b0, 8'h20, 8'h00, 8'h00, eer_pkg::FLAG_INDEF, eer_pkg::CODE_INDEF, 1'b0);
        seq(4, 1'b1, 8'h00, 8'h01, 8'h06, eer_pkg::FLAG_INDEF, eer_pkg::CODE_INDEF, 1'b0);
        seq(5, 1'b0, 8'h04, 8'h03, 8'h02, eer_pkg::FLAG_NONE, eer_pkg::CODE_HW, 1'b0);
        seq(5, 1'b1, 8'h04, 8'h03, 8'h02, eer_pkg::FLAG_NONE, eer_pkg::CODE_HW, 1'b0);
        seq(6, 1'b0, 8'h04, 8'h03, 8'h02, eer_pkg::FLAG_NONE, eer_pkg::CODE_HW, 1'b0);
        seq(6, 1'b1, 8'h04, 8'h03, 8'h02, eer_pkg::FLAG_NONE, eer_pkg::CODE_HW, 1'b0);
        results();
    end
endmodule
